// [rtl/ecr_defs.svh]
// Constants of the event channel router: register indices, fields, codes.
// Assumes inclusion by bare name from the package and the router.
`ifndef ECR_DEFS_SVH
`define ECR_DEFS_SVH

`define ECR_ADDR_W 7
`define ECR_NUM_CH 8
`define ECR_NUM_PIN 48
`define ECR_PRE_W 15

`define ECR_IDX_MUX0 5'h00
`define ECR_IDX_CTRL0 5'h08
`define ECR_IDX_TRIG 5'h10
`define ECR_IDX_VAL 5'h11
`define ECR_IDX_STAT 5'h12
`define ECR_IDX_MASK 5'h13

`define ECR_RST_REG 8'h00
`define ECR_CTRL_WMASK_QUAD 8'h7F
`define ECR_CTRL_WMASK_PLAIN 8'h07
`define ECR_CTRL_MODE_HI 6
`define ECR_CTRL_MODE_LO 5
`define ECR_CTRL_IDXEN 4
`define ECR_CTRL_QUADRATURE_DECODE_ENABLE 3

`define ECR_SEL_USB 8'h0A
`define ECR_HI_NONE 4'h0
`define ECR_HI_PORT_AB 4'h5
`define ECR_HI_PORT_CD 4'h6
`define ECR_HI_PORT_EF 4'h7
`define ECR_HI_PRESC 4'h8
`define ECR_HI_TC_C 4'hC
`define ECR_HI_TC_D 4'hD
`define ECR_HI_TC_E 4'hE
`define ECR_HI_TC_F 4'hF

`define ECR_EV_WRAP 3'h0
`define ECR_EV_FAULT 3'h1
`define ECR_EV_CHA 3'h4
`define ECR_EV_CHB 3'h5
`define ECR_EV_CHC 3'h6
`define ECR_EV_CHD 3'h7

`define ECR_RESP_OKAY 2'h0
`define ECR_RESP_SLVERR 2'h2

`endif

// [rtl/ecr_pkg.sv]
// Types of the event channel router.
// Assumes ecr_defs.svh on the include path.
`include "ecr_defs.svh"

package ecr_pkg;

  // Events of the eight counters; c and d exist on even counters only
  typedef struct packed {
    logic [7:0] wrap;
    logic [7:0] fault;
    logic [7:0] cha;
    logic [7:0] chb;
    logic [3:0] chc;
    logic [3:0] chd;
  } ecr_ctr_ev_t;

  typedef struct packed {
    logic [7:0][7:0] mux;
    logic [7:0][7:0] ctrl;
    logic [7:0] trig;
    logic [7:0] val;
    logic [7:0] stat;
    logic [7:0] mask;
    logic [47:0] s1;
    logic [47:0] s2;
    logic [47:0] s3;
    logic [47:0] lvl;
    logic [14:0] pre;
    logic [7:0] prev;
    logic [7:0][2:0] cnt;
    logic [7:0] filt;
    logic [7:0] ev_out;
    logic [7:0] ev_data;
    logic [2:0] qmatch;
    logic [2:0] idx_ev;
    logic irq;
    logic aw_held;
    logic w_held;
    logic [4:0] waddr;
    logic [7:0] wdata;
    logic wstb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [4:0] raddr;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } ecr_state_t;

endpackage : ecr_pkg

// [rtl/ecr_router.sv]
// Event channel router: source selection, filtering, quadrature index,
// manual events, interrupt status, AXI4-Lite register slave.
// Assumes all event sources except port pins run on ref_clk.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "ecr_defs.svh"

// Notes on behaviour
// - Nibbles 0101-0111 pick a port pin; bit 3 picks port, low bits pin.
// - Nibble 1000 gives peripheral clock divided by two to the M.
// - Nibbles 1100-1111 with bit 3 pick one of eight counters.
// - Type 000 wrap, 001 fault, 01x reserved, 100/101 channels A/B.
// - Types 110/111 give channels C/D, only on even counters.
// - USB sources reach channels zero to three only.
// - Control bit 7 reads zero; software writes it as zero.
// - Mode field picks the phase pair state that marks an index.
// - Control bit 4 makes the channel an index source.
// - Control bit 3 enables quadrature decoding.
// - Quadrature fields exist only on channels 0, 2 and 4.
// - Event passes after filter field plus one equal samples.
// - Nonzero trigger write drives each channel with trigger and value bits.
// - A manual event lasts exactly one clock cycle.
// - Selector zero routes nothing; manual events still pass.
// - Absent or reserved sources behave as selector zero.
module ecr_router (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [`ECR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`ECR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [47:0] port_pin_event,
  input wire ecr_pkg::ecr_ctr_ev_t counter_events,
  input wire logic [3:0] usb_event,
  output logic [7:0] chan_event,
  output logic [7:0] chan_data,
  output logic [2:0] index_event,
  output logic [2:0] quadrature_decode_enable,
  output logic [2:0] index_source_enable,
  output logic irq
);

  ecr_pkg::ecr_state_t st;
  ecr_pkg::ecr_state_t nx;
  logic [7:0] src_raw;
  logic [15:0] tick;
  logic do_wr;
  logic wr_hit;
  logic [7:0] strobe;
  logic [7:0] clr;
  logic [7:0] rd_val;
  logic [4:0] rd_idx;

  assign s_axi_awready = !st.aw_held && !st.bvalid;
  assign s_axi_wready = !st.w_held && !st.bvalid;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rdata = {24'h000000, st.rdata};
  assign chan_event = st.ev_out;
  assign chan_data = st.ev_data;
  assign index_event = st.idx_ev;
  assign irq = st.irq;
  assign rd_idx = s_axi_araddr[`ECR_ADDR_W-1:2];
  assign do_wr = st.aw_held && st.w_held && !st.bvalid;
  assign wr_hit = st.waddr <= `ECR_IDX_MASK;

  // quad bits of channels 0, 2, 4
  always_comb begin
    for (int q = 0; q < 3; q++) begin
      quadrature_decode_enable[q] = st.ctrl[2*q][`ECR_CTRL_QUADRATURE_DECODE_ENABLE];
      index_source_enable[q] = st.ctrl[2*q][`ECR_CTRL_IDXEN];
    end
  end

  // prescaler ticks, one every 2^M cycles
  always_comb begin
    logic [14:0] msk;
    msk = 15'h0000;
    tick[0] = 1'b1;
    for (int m = 1; m < 16; m++) begin
      msk = (15'h0001 << m) - 15'h0001;
      tick[m] = (st.pre & msk) == 15'h0000;
    end
  end

  // Source selection per channel
  always_comb begin
    logic [7:0] sel;
    logic [3:0] hi;
    logic [2:0] ctr;
    sel = 8'h00;
    hi = 4'h0;
    ctr = 3'h0;
    for (int c = 0; c < `ECR_NUM_CH; c++) begin
      sel = st.mux[c];
      hi = sel[7:4];
      ctr = {hi[1:0], sel[3]};
      src_raw[c] = 1'b0;
      case (hi)
        `ECR_HI_NONE: begin
          if (sel == `ECR_SEL_USB && c < 4) begin
            src_raw[c] = usb_event[c[1:0]];
          end
        end
        `ECR_HI_PORT_AB, `ECR_HI_PORT_CD, `ECR_HI_PORT_EF: begin
          src_raw[c] = st.lvl[{hi[1:0] - 2'h1, sel[3:0]}];
        end
        `ECR_HI_PRESC: begin
          src_raw[c] = tick[sel[3:0]];
        end
        `ECR_HI_TC_C, `ECR_HI_TC_D, `ECR_HI_TC_E, `ECR_HI_TC_F: begin
          case (sel[2:0])
            `ECR_EV_WRAP: src_raw[c] = counter_events.wrap[ctr];
            `ECR_EV_FAULT: src_raw[c] = counter_events.fault[ctr];
            `ECR_EV_CHA: src_raw[c] = counter_events.cha[ctr];
            `ECR_EV_CHB: src_raw[c] = counter_events.chb[ctr];
            // C and D on even counters
            `ECR_EV_CHC: src_raw[c] = !sel[3] && counter_events.chc[hi[1:0]];
            `ECR_EV_CHD: src_raw[c] = !sel[3] && counter_events.chd[hi[1:0]];
            default: src_raw[c] = 1'b0;
          endcase
        end
        default: src_raw[c] = 1'b0;
      endcase
    end
  end

  // Read mux; unmapped reads return zero
  always_comb begin
    rd_val = 8'h00;
    if (rd_idx < `ECR_IDX_CTRL0) begin
      rd_val = st.mux[rd_idx[2:0]];
    end else if (rd_idx < `ECR_IDX_TRIG) begin
      rd_val = st.ctrl[rd_idx[2:0]];
    end else if (rd_idx == `ECR_IDX_TRIG) begin
      rd_val = st.trig;
    end else if (rd_idx == `ECR_IDX_VAL) begin
      rd_val = st.val;
    end else if (rd_idx == `ECR_IDX_STAT) begin
      rd_val = st.stat;
    end else if (rd_idx == `ECR_IDX_MASK) begin
      rd_val = st.mask;
    end
  end

  always_comb begin
    logic match;
    match = 1'b0;
    nx = st;
    strobe = 8'h00;
    clr = 8'h00;
    if (s_axi_awvalid && s_axi_awready) begin
      nx.aw_held = 1'b1;
      nx.waddr = s_axi_awaddr[`ECR_ADDR_W-1:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nx.w_held = 1'b1;
      nx.wdata = s_axi_wdata[7:0];
      nx.wstb = s_axi_wstrb[0];
    end
    if (st.bvalid && s_axi_bready) begin
      nx.bvalid = 1'b0;
    end
    if (do_wr) begin
      nx.aw_held = 1'b0;
      nx.w_held = 1'b0;
      nx.bvalid = 1'b1;
      nx.bresp = wr_hit ? `ECR_RESP_OKAY : `ECR_RESP_SLVERR;
      if (wr_hit && st.wstb) begin
        if (st.waddr < `ECR_IDX_CTRL0) begin
          nx.mux[st.waddr[2:0]] = st.wdata;
        end else if (st.waddr < `ECR_IDX_TRIG) begin
          // drop bit 7 and absent quad bits
          if (!st.waddr[0] && st.waddr[2:0] != 3'h6) begin
            nx.ctrl[st.waddr[2:0]] = st.wdata & `ECR_CTRL_WMASK_QUAD;
          end else begin
            nx.ctrl[st.waddr[2:0]] = st.wdata & `ECR_CTRL_WMASK_PLAIN;
          end
        end else if (st.waddr == `ECR_IDX_TRIG) begin
          nx.trig = st.wdata;
          strobe = st.wdata;
        end else if (st.waddr == `ECR_IDX_VAL) begin
          nx.val = st.wdata;
        end else if (st.waddr == `ECR_IDX_STAT) begin
          clr = st.wdata;
        end else begin
          nx.mask = st.wdata;
        end
      end
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nx.rvalid = 1'b1;
      nx.raddr = rd_idx;
      nx.rdata = rd_val;
      nx.rresp = (rd_idx <= `ECR_IDX_MASK) ? `ECR_RESP_OKAY : `ECR_RESP_SLVERR;
    end else if (st.rvalid && s_axi_rready) begin
      nx.rvalid = 1'b0;
    end
    // Pins are asynchronous; third stage must agree with second
    nx.s1 = port_pin_event;
    nx.s2 = st.s1;
    nx.s3 = st.s2;
    nx.lvl = (~(st.s2 ^ st.s3) & st.s3) | ((st.s2 ^ st.s3) & st.lvl);
    nx.pre = st.pre + 15'h0001;
    for (int c = 0; c < `ECR_NUM_CH; c++) begin
      nx.prev[c] = src_raw[c];
      if (src_raw[c] != st.prev[c]) begin
        nx.cnt[c] = 3'h0;
      end else if (st.cnt[c] != 3'h7) begin
        nx.cnt[c] = st.cnt[c] + 3'h1;
      end
      // pass after field plus one samples
      if (nx.cnt[c] >= st.ctrl[c][2:0]) begin
        nx.filt[c] = src_raw[c];
      end
    end
    // manual pulse for one write only
    nx.ev_out = nx.filt | strobe;
    nx.ev_data = strobe & st.val;
    for (int q = 0; q < 3; q++) begin
      match = {st.filt[2*q], st.filt[2*q+1]} == st.ctrl[2*q][6:5];
      nx.qmatch[q] = match;
      nx.idx_ev[q] = st.ctrl[2*q][`ECR_CTRL_IDXEN] && st.ctrl[2*q][`ECR_CTRL_QUADRATURE_DECODE_ENABLE]
                     && match && !st.qmatch[q];
    end
    // Set wins over a same-cycle clear
    nx.stat = (st.stat & ~clr) | (nx.ev_out & ~st.ev_out);
    nx.irq = |(nx.stat & nx.mask);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_manual_write;
    do_wr && st.wstb && st.waddr == `ECR_IDX_TRIG && st.wdata != 8'h00;
  endsequence

  sequence s_half_rate;
    st.mux[6] == 8'h81 ##1 st.mux[6] == 8'h81;
  endsequence

  sequence s_write_ready;
    st.aw_held && st.w_held && !st.bvalid;
  endsequence

  AST_CTRL_BIT7: assert property (
    st.rvalid && st.raddr >= `ECR_IDX_CTRL0 && st.raddr < `ECR_IDX_TRIG |-> !st.rdata[7])
    else $error("control bit 7 read as one");

  AST_QUAD_ABSENT: assert property (
    (st.ctrl[1][6:3] | st.ctrl[3][6:3] | st.ctrl[5][6:3] | st.ctrl[6][6:3]
     | st.ctrl[7][6:3]) == 4'h0)
    else $error("quadrature bits held on a plain channel");

  AST_MANUAL_FIRE: assert property (
    s_manual_write |=> (st.ev_out & $past(st.wdata)) == $past(st.wdata)
    && st.ev_data == ($past(st.wdata) & $past(st.val)))
    else $error("manual trigger not driven on channels");

  AST_MANUAL_ONE_CYCLE: assert property (
    st.ev_data != 8'h00 |=> st.ev_data == 8'h00)
    else $error("manual data event longer than one cycle");

  AST_FILTER_COUNT: assert property (
    $changed(st.filt[0]) |-> st.cnt[0] >= $past(st.ctrl[0][2:0]))
    else $error("filter passed before enough samples");

  AST_ONE_SAMPLE: assert property (
    st.ctrl[0][2:0] == 3'h0 && src_raw[0] != st.filt[0] |=> st.filt[0] == $past(src_raw[0]))
    else $error("single sample filter added delay");

  AST_SELECT_ZERO: assert property (
    st.mux[2] == 8'h00 [*8] ##1 st.mux[2] == 8'h00 |-> !st.filt[2])
    else $error("event routed with selector zero");

  AST_HALF_RATE: assert property (
    s_half_rate |-> src_raw[6] != $past(src_raw[6]))
    else $error("prescaler by two does not alternate");

  AST_USB_HIGH_CH: assert property (
    st.mux[4] == `ECR_SEL_USB |-> !src_raw[4])
    else $error("USB source reached a high channel");

  AST_CD_ODD_CTR: assert property (
    st.mux[2][7:6] == 2'h3 && st.mux[2][3] && st.mux[2][2:1] == 2'h3 |-> !src_raw[2])
    else $error("channel C or D taken from an odd counter");

  AST_INDEX_CAUSE: assert property (
    st.idx_ev[0] |-> $past(st.ctrl[0][4:3]) == 2'h3
    && $past({st.filt[0], st.filt[1]}) == $past(st.ctrl[0][6:5]))
    else $error("index event without enable and matching state");

  AST_INDEX_ONE_CYCLE: assert property (
    st.idx_ev[0] |=> !st.idx_ev[0])
    else $error("index event longer than one cycle");

  AST_RESERVED_TYPE: assert property (
    st.mux[2][7:6] == 2'h3 && st.mux[2][2:1] == 2'h1 |-> !src_raw[2])
    else $error("reserved counter event type routed");

  AST_USB_LOW_CH: assert property (
    st.mux[0] == `ECR_SEL_USB |-> src_raw[0] == usb_event[0])
    else $error("USB source missing on a low channel");

  AST_ZERO_TRIGGER: assert property (
    do_wr && st.wstb && st.waddr == `ECR_IDX_TRIG && st.wdata == 8'h00 |=> st.ev_data == 8'h00)
    else $error("zero trigger write fired a data event");

  // Status set wins over a clear in the same cycle
  AST_STAT_SET_WINS: assert property (
    (st.stat & st.ev_out & ~$past(st.ev_out)) == (st.ev_out & ~$past(st.ev_out)))
    else $error("rising channel event not held in status");

  AST_IRQ_LEVEL: assert property (
    st.irq == |(st.stat & st.mask))
    else $error("interrupt level differs from masked status");

  AST_PIN_AGREE: assert property (
    st.s2 == st.s3 |=> st.lvl == $past(st.s3))
    else $error("pin level not taken on agreeing stages");

  AST_WRITE_ANSWER: assert property (
    s_write_ready |=> st.bvalid && !st.aw_held && !st.w_held)
    else $error("write response not given one cycle after both halves");

  AST_READ_ANSWER: assert property (
    s_axi_arvalid && s_axi_arready |=> st.rvalid)
    else $error("read response not given one cycle after address");

  AST_BVALID_HOLD: assert property (
    st.bvalid && !s_axi_bready |=> st.bvalid && $stable(st.bresp))
    else $error("write response dropped before acceptance");

  AST_RVALID_HOLD: assert property (
    st.rvalid && !s_axi_rready |=> st.rvalid && $stable(st.rdata))
    else $error("read response dropped before acceptance");

endmodule : ecr_router

// [verification/ecr_ctr_model.sv]
// Counter event sources facing the router: one-cycle pulses on request.
// Assumes requests arrive just after a rising ref_clk edge.
`timescale 1ns/10ps
module ecr_ctr_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic fire,
  input wire logic [2:0] k,
  input wire logic [2:0] ty,
  output ecr_pkg::ecr_ctr_ev_t ev
);
  logic rsv;
  assign rsv = ty[2:1] == 2'h1;
  // type lines
  // Reserved types light every line, so the router must pick none of them
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ev <= '0;
    end else begin
      ev <= '0;
      if (fire) begin
        ev.wrap[k] <= ty == 3'h0 || rsv;
        ev.fault[k] <= ty == 3'h1 || rsv;
        ev.cha[k] <= ty == 3'h4 || rsv;
        ev.chb[k] <= ty == 3'h5 || rsv;
        ev.chc[k[2:1]] <= ty == 3'h6 || rsv;
        ev.chd[k[2:1]] <= ty == 3'h7 || rsv;
      end
    end
  end
endmodule : ecr_ctr_model

// [verification/event_channel_routing_bench.sv]
// Self-checking bench of the event channel router.
// Assumes the router and the counter source model; pins driven here.
`timescale 1ns/10ps
module event_channel_routing_bench;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [6:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb = '0, usb_event = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [47:0] port_pin_event = '0;
  ecr_pkg::ecr_ctr_ev_t counter_events;
  logic fire = 0;
  logic [2:0] k = '0, ty = '0;
  logic [7:0] chan_event, chan_data, ev_or, dat_or;
  logic [2:0] index_event, quadrature_decode_enable, index_source_enable, idx_or;
  int fails = 0, n_compared = 0, cyc = 0, hi_cnt = 0;

  ecr_router ecr_router_inst (.*);
  ecr_ctr_model ecr_ctr_model_inst (.ref_clk, .rstn, .fire, .k, .ty, .ev(counter_events));

  always #4 ref_clk = ~ref_clk;

  // Sampled mid-cycle so the clearing by tasks never races the edge
  always @(negedge ref_clk) begin
    ev_or |= chan_event;
    dat_or |= chan_data;
    idx_or |= index_event;
    if (chan_event != 8'h00) hi_cnt++;
    cyc++;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  task automatic clr;
    ev_or = '0;
    dat_or = '0;
    idx_or = '0;
    hi_cnt = 0;
  endtask : clr

  // Waits for the answer however long; only the cycle ceiling ends a hang
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    s_axi_awaddr <= {a, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [4:0] a);
    s_axi_araddr <= {a, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
  endtask : rd

  task automatic t_regs;
    rd(5'h08);
    chk(v, 32'h0);
    wr(5'h08, 8'h7F);
    wr(5'h0A, 8'h08);
    wr(5'h0C, 8'h10);
    rd(5'h08);
    chk(v, 32'h7F);
    chk(32'({quadrature_decode_enable, index_source_enable}), 32'h1D);
    wr(5'h09, 8'h7F);
    rd(5'h09);
    chk(v, 32'h07);
    wr(5'h1F, 8'h01);
    chk(32'(r), 32'h2);
    rd(5'h1F);
    chk(32'(r), 32'h2);
    wr(5'h08, 8'h00);
    wr(5'h09, 8'h00);
    wr(5'h0A, 8'h00);
    wr(5'h0C, 8'h00);
  endtask : t_regs

  task automatic t_man;
    wr(5'h11, 8'h0F);
    clr();
    wr(5'h10, 8'h33);
    tick(2);
    chk(32'(ev_or), 32'h33);
    chk(32'(dat_or), 32'h03);
    chk(32'(hi_cnt), 32'h1);
    rd(5'h12);
    chk(v, 32'h33);
    chk(32'(irq), 32'h0);
    wr(5'h13, 8'h01);
    chk(32'(irq), 32'h1);
    wr(5'h12, 8'h33);
    chk(32'(irq), 32'h0);
    clr();
    wr(5'h10, 8'h00);
    tick(2);
    chk(32'(ev_or), 32'h0);
    wr(5'h13, 8'h00);
  endtask : t_man

  // Every counter and type; selector is {2'b11, counter, type}
  task automatic t_src;
    int j;
    logic e;
    for (j = 0; j < 64; j++) begin
      wr(5'h02, {2'h3, j[5:0]});
      e = j[2:1] != 2'h1 && !(j[2:1] == 2'h3 && j[3]);
      clr();
      k <= j[5:3];
      ty <= j[2:0];
      fire <= 1'b1;
      tick(1);
      fire <= 1'b0;
      tick(8);
      chk(32'(ev_or[2]), 32'(e));
    end
  endtask : t_src

  // Four samples needed: three-cycle glitch dies, five-cycle level passes
  task automatic t_pin;
    int p, w;
    wr(5'h0D, 8'h03);
    for (p = 0; p < 6; p++) begin
      wr(5'h05, 8'h50 + 8'(p * 9));
      for (w = 3; w < 6; w += 2) begin
        clr();
        port_pin_event[p * 9] <= 1'b1;
        tick(w);
        port_pin_event <= '0;
        tick(12);
        chk(32'(ev_or[5]), 32'(w == 5));
      end
    end
  endtask : t_pin

  task automatic t_pre;
    int m;
    for (m = 0; m < 5; m++) begin
      wr(5'h06, 8'h80 + 8'(m));
      tick(40);
      clr();
      tick(64);
      chk(32'(hi_cnt), 32'(64 >> m));
    end
    wr(5'h06, 8'h00);
  endtask : t_pre

  task automatic t_usb;
    wr(5'h00, 8'h0A);
    wr(5'h04, 8'h0A);
    clr();
    usb_event <= 4'hF;
    tick(1);
    usb_event <= 4'h0;
    tick(6);
    chk(32'({ev_or[4], ev_or[0]}), 32'h1);
  endtask : t_usb

  task automatic t_quad;
    int m;
    wr(5'h00, 8'h50);
    wr(5'h01, 8'h51);
    for (m = 0; m < 4; m++) begin
      // mode set with index phases wired
      wr(5'h08, {1'b0, 2'(m), 5'h18});
      clr();
      port_pin_event[1:0] <= ~{m[0], m[1]};
      tick(12);
      chk(32'(idx_or), 32'h0);
      clr();
      port_pin_event[1:0] <= {m[0], m[1]};
      tick(12);
      chk(32'(idx_or), 32'h1);
    end
  endtask : t_quad

  initial begin
    tick(8);
    rstn <= 1'b1;
    tick(1);
    t_regs();
    t_man();
    t_src();
    t_pin();
    t_pre();
    t_usb();
    t_quad();
    give_verdict();
  end
endmodule : event_channel_routing_bench
